/* verif/lintp_host_model.sv */
`timescale 1ns/10ps
// host pin on the enable line: short high pulse, then back to input
module lintp_host_model (
  input wire logic sys_clk_i,
  input wire logic start_i,
  output logic pin_o,
  output logic pin_oe_o
);
  logic [2:0] cnt_q = 3'h0;
  // drive for four cycles only, then release so the device owns the pin
  always @(posedge sys_clk_i) begin
    if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end else if (start_i) begin
      cnt_q <= 3'h4;
    end
  end
  assign pin_oe_o = (cnt_q != 3'h0);
  assign pin_o = (cnt_q != 3'h0);
endmodule

/* verif/test_lin_transceiver_host_port.sv */
`timescale 1ns/10ps
module test_lin_transceiver_host_port;
  import lintp_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic send_data_i = 1'b1;
  logic lin_fault_i = 1'b0;
  logic sleep_req_i = 1'b0;
  logic tb_dom = 1'b0;
  logic start = 1'b0;
  logic recv_data_o, recv_data_oe_o, bus_o, bus_oe_o, asleep_o, wake_o;
  logic pin_o, pin_oe_o, pin_weak_o, host_o, host_oe;
  int mismatches = 0;
  int checked = 0;
  // bus and receive pin pulled up; enable pin pulled down when nobody drives
  wire logic bus_w = bus_oe_o ? bus_o : (tb_dom ? BUS_DOMINANT : BUS_RECESSIVE);
  wire logic recv_w = recv_data_oe_o ? recv_data_o : 1'b1;
  // host only wins over a resistive device drive, never over a strong one
  wire logic pin_w = (pin_oe_o && !pin_weak_o) ? pin_o :
    (host_oe ? host_o : (pin_oe_o ? pin_o : 1'b0));

  always #20 sys_clk_i = ~sys_clk_i;

  // short wake threshold keeps the run brief
  lintp_top #(.WAKE_CYCLES(8)) i_dut (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .send_data_i(send_data_i),
    .recv_data_o(recv_data_o),
    .recv_data_oe_o(recv_data_oe_o),
    .bus_i(bus_w),
    .bus_o(bus_o),
    .bus_oe_o(bus_oe_o),
    .fault_flag_send_enable_pin_i(pin_w),
    .fault_flag_send_enable_pin_o(pin_o),
    .fault_flag_send_enable_pin_oe_o(pin_oe_o),
    .fault_flag_send_enable_pin_weak_o(pin_weak_o),
    .lin_fault_i(lin_fault_i),
    .sleep_req_i(sleep_req_i),
    .asleep_o(asleep_o),
    .wake_o(wake_o)
  );

  lintp_host_model i_host (
    .sys_clk_i(sys_clk_i),
    .start_i(start),
    .pin_o(host_o),
    .pin_oe_o(host_oe)
  );

  task automatic check(input logic seen, input logic exp, input string msg);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic pulse_host;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
  endtask

  // enable handshake, then one dominant and one recessive bit
  task automatic enable_and_send;
    pulse_host();
    cyc(8);
    check(pin_oe_o, 1'b1, "enable not driven");
    check(pin_w, 1'b1, "pin not held high");
    send_data_i = 1'b0;
    cyc(4);
    check(bus_w, BUS_DOMINANT, "bus not dominant");
    send_data_i = 1'b1;
    cyc(4);
    check(bus_w, BUS_RECESSIVE, "bus not recessive");
  endtask

  task automatic receive_follow;
    tb_dom = 1'b1;
    cyc(5);
    check(recv_w, 1'b0, "rx not low");
    check(recv_data_o, 1'b0, "rx drives high");
    tb_dom = 1'b0;
    cyc(5);
    check(recv_w, 1'b1, "rx not high");
  endtask

  // fault pulls pin low weakly; pulse during fault is refused
  task automatic fault_blocks;
    lin_fault_i = 1'b1;
    cyc(4);
    check(pin_oe_o, 1'b1, "fault not driven");
    check(pin_o, 1'b0, "fault not low");
    check(pin_weak_o, 1'b1, "fault drive strong");
    check(pin_w, 1'b0, "fault not seen on pin");
    send_data_i = 1'b0;
    pulse_host();
    cyc(2);
    check(pin_w, 1'b1, "host cannot overdrive");
    cyc(4);
    check(bus_oe_o, 1'b0, "bus driven in fault");
    lin_fault_i = 1'b0;
    cyc(6);
    check(bus_oe_o, 1'b0, "bus driven without pulse");
    send_data_i = 1'b1;
  endtask

  // re-enable after the fault, then a reset in mid-run must drop the enable
  task automatic reset_mid_run;
    pulse_host();
    cyc(8);
    check(pin_oe_o, 1'b1, "no enable after fault cleared");
    rst_n_i = 1'b0;
    cyc(2);
    check(pin_oe_o, 1'b0, "enable kept in reset");
    check(pin_weak_o, 1'b1, "pin drive strong in reset");
    rst_n_i = 1'b1;
    send_data_i = 1'b0;
    cyc(6);
    check(bus_oe_o, 1'b0, "bus driven after reset");
    check(pin_w, 1'b0, "pin high after reset");
    send_data_i = 1'b1;
    cyc(3);
  endtask

  task automatic sleep_wake;
    logic seen;
    sleep_req_i = 1'b1;
    cyc(6);
    check(asleep_o, 1'b1, "not asleep");
    sleep_req_i = 1'b0;
    // an enable pulse while asleep is refused
    pulse_host();
    cyc(8);
    check(pin_oe_o, 1'b0, "enabled while asleep");
    // dominant too short: must not wake
    tb_dom = 1'b1;
    cyc(4);
    tb_dom = 1'b0;
    seen = 1'b0;
    repeat (10) begin
      cyc(1);
      seen = seen | wake_o;
    end
    check(seen, 1'b0, "woke on short dominant");
    tb_dom = 1'b1;
    cyc(12);
    tb_dom = 1'b0;
    seen = 1'b0;
    repeat (10) begin
      cyc(1);
      seen = seen | wake_o;
    end
    check(seen, 1'b1, "no wake");
    check(asleep_o, 1'b0, "still asleep");
  endtask

  initial begin
    cyc(4);
    rst_n_i = 1'b1;
    cyc(3);
    enable_and_send();
    receive_follow();
    fault_blocks();
    reset_mid_run();
    sleep_wake();
    complete_run();
  end

  // the tests need a few hundred cycles at most
  initial begin
    #(40 * 2000);
    mismatches++;
    complete_run();
  end
endmodule

/* verilog/lintp_buf.sv */
`timescale 1ns/10ps
// two-entry skid buffer, receiver stall never drops a word
module lintp_buf
  import lintp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [WIDTH-1:0] mem_q [BUF_DEPTH];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign push = in_valid_i && (cnt_q != 2'd2);
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != 2'd2);
  assign out_valid_o = (cnt_q != 2'd0);
  assign out_data_o = mem_q[rd_q];

  // storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  AST_NO_OVERFLOW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cnt_q <= 2'd2) else $error("buffer count past depth");
endmodule

/* verilog/lintp_pkg.sv */
package lintp_pkg;
  // wake threshold: dominant bus must last longer than this
  localparam int WAKE_NS = 150000;
  localparam int CLK_NS = 40;
  // longest-time style figure, but "longer than": round up so a shorter pulse never wakes
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CW = 13;
  localparam int BUF_DEPTH = 2;
  // levels of the bus and pins
  localparam logic BUS_DOMINANT = 1'b0;
  localparam logic BUS_RECESSIVE = 1'b1;
  localparam logic RST_VAL_ENABLE = 1'b0;

  // a bus sample travelling to the receive pin
  typedef struct packed {
    logic level;
  } lintp_bit_type;

  typedef enum logic [1:0] {
    LINTP_ACTIVE,
    LINTP_SLEEP,
    LINTP_WAKE_ARMED
  } lintp_state_type;
endpackage

/* verilog/lintp_top.sv */
`timescale 1ns/10ps
// Operation
// - receive output follows the bus level continuously, four clock cycles late.
// - receive output is open drain, only ever pulls low.
// - transmit low drives bus dominant; transmit high leaves bus recessive.
// - on a bus fault, pull the enable pin low, weakly, host may overdrive.
// - enable pulse without fault latches enable; pin then held high weakly. Code ignores the pulse while asleep.
// - asleep, wake on rising bus edge after dominant longer than threshold.
module lintp_top
  import lintp_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic send_data_i,
  output logic recv_data_o,
  output logic recv_data_oe_o,
  input wire logic bus_i,
  output logic bus_o,
  output logic bus_oe_o,
  input wire logic fault_flag_send_enable_pin_i,
  output logic fault_flag_send_enable_pin_o,
  output logic fault_flag_send_enable_pin_oe_o,
  output logic fault_flag_send_enable_pin_weak_o,
  input wire logic lin_fault_i,
  input wire logic sleep_req_i,
  output logic asleep_o,
  output logic wake_o
);
  // two-flop synchronisers for every pin input
  logic [1:0] txd_s_q;
  logic [1:0] bus_s_q;
  logic [1:0] fen_s_q;
  logic [1:0] flt_s_q;
  logic [1:0] slp_s_q;
  logic fen_prev_q;
  logic bus_prev_q;
  logic enable_q;
  lintp_state_type state_q;
  logic [WAKE_CW-1:0] dom_cnt_q;
  lintp_bit_type rx_in;
  lintp_bit_type rx_out;
  logic rx_valid;
  logic rx_in_ready;

  // pin inputs pass two flops before any logic reads them
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txd_s_q <= {2{BUS_RECESSIVE}};
      bus_s_q <= {2{BUS_RECESSIVE}};
      fen_s_q <= 2'b00;
      flt_s_q <= 2'b00;
      slp_s_q <= 2'b00;
    end else begin
      txd_s_q <= {txd_s_q[0], send_data_i};
      bus_s_q <= {bus_s_q[0], bus_i};
      fen_s_q <= {fen_s_q[0], fault_flag_send_enable_pin_i};
      flt_s_q <= {flt_s_q[0], lin_fault_i};
      slp_s_q <= {slp_s_q[0], sleep_req_i};
    end
  end

  // edge history, read only from the second flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fen_prev_q <= 1'b0;
      bus_prev_q <= BUS_RECESSIVE;
    end else begin
      fen_prev_q <= fen_s_q[1];
      bus_prev_q <= bus_s_q[1];
    end
  end

  // send enable latch: set by host pulse without fault while active, dropped by fault
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_q <= RST_VAL_ENABLE;
    end else if (flt_s_q[1] || state_q != LINTP_ACTIVE) begin
      enable_q <= 1'b0;
    end else if (fen_s_q[1] && !fen_prev_q) begin
      enable_q <= 1'b1;
    end
  end

  // enable pin: weak low on fault through series resistance, weak high when latched
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_flag_send_enable_pin_o <= 1'b0;
      fault_flag_send_enable_pin_oe_o <= 1'b0;
      fault_flag_send_enable_pin_weak_o <= 1'b1;
    end else begin
      fault_flag_send_enable_pin_o <= !flt_s_q[1] && enable_q;
      fault_flag_send_enable_pin_oe_o <= flt_s_q[1] || enable_q;
      fault_flag_send_enable_pin_weak_o <= 1'b1; // host can always overdrive
    end
  end

  // bus driver: open drain, dominant only while enabled and transmit low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_o <= BUS_DOMINANT;
      bus_oe_o <= 1'b0;
    end else begin
      bus_o <= BUS_DOMINANT;
      bus_oe_o <= enable_q && !flt_s_q[1] && (txd_s_q[1] == BUS_DOMINANT);
    end
  end

  // sleep state machine with dominant-time qualified wake
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= LINTP_ACTIVE;
      dom_cnt_q <= '0;
      wake_o <= 1'b0;
      asleep_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      case (state_q)
        LINTP_ACTIVE: begin
          dom_cnt_q <= '0;
          if (slp_s_q[1]) begin
            state_q <= LINTP_SLEEP;
          end
        end
        LINTP_SLEEP: begin
          // saturating count of dominant time; short glitches restart it
          if (bus_s_q[1] == BUS_DOMINANT) begin
            if (dom_cnt_q < WAKE_CW'(WAKE_CYCLES)) begin
              dom_cnt_q <= dom_cnt_q + 1'b1;
            end else begin
              state_q <= LINTP_WAKE_ARMED;
            end
          end else begin
            dom_cnt_q <= '0;
          end
        end
        LINTP_WAKE_ARMED: begin
          if (bus_s_q[1] == BUS_RECESSIVE && bus_prev_q == BUS_DOMINANT) begin
            state_q <= LINTP_ACTIVE;
            wake_o <= 1'b1;
          end
        end
        default: begin
          state_q <= LINTP_ACTIVE;
        end
      endcase
      asleep_o <= (state_q != LINTP_ACTIVE);
    end
  end

  // bus samples pass the skid buffer to the receive pin; it is always drained
  assign rx_in.level = bus_s_q[1];

  lintp_buf #(
    .WIDTH($bits(lintp_bit_type))
  ) u_rx_buf (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(rx_in),
    .in_valid_i(1'b1),
    .in_ready_o(rx_in_ready),
    .out_data_o(rx_out),
    .out_valid_o(rx_valid),
    .out_ready_i(1'b1)
  );

  // receive pin only sinks; high comes from external pull-up
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recv_data_o <= 1'b0;
      recv_data_oe_o <= 1'b0;
    end else begin
      recv_data_o <= 1'b0;
      if (rx_valid && rx_in_ready) begin
        recv_data_oe_o <= (rx_out.level == BUS_DOMINANT);
      end
    end
  end

  AST_RX_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(bus_s_q[1]) |-> ##2 recv_data_oe_o) else $error("rx not following dominant");
  AST_RX_OPEN_DRAIN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    recv_data_oe_o |-> !recv_data_o) else $error("rx driven high");
  AST_TX_DOMINANT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (enable_q && !flt_s_q[1] && !txd_s_q[1]) |=> bus_oe_o && !bus_o)
    else $error("tx low not dominant");
  AST_TX_RECESSIVE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    txd_s_q[1] |=> !bus_oe_o) else $error("tx high drives bus");
  AST_FAULT_PULLS_LOW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    flt_s_q[1] |=> fault_flag_send_enable_pin_oe_o && !fault_flag_send_enable_pin_o)
    else $error("fault not signalled");
  // a fault or sleep in the cycle after the edge legally cancels the latch
  AST_ENABLE_LATCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ($rose(fen_s_q[1]) && !flt_s_q[1] && state_q == LINTP_ACTIVE) ##1
    (!flt_s_q[1] && state_q == LINTP_ACTIVE) |=>
    (fault_flag_send_enable_pin_o && fault_flag_send_enable_pin_oe_o))
    else $error("enable not latched");
  AST_FAULT_BLOCKS_TX: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    flt_s_q[1] |=> !bus_oe_o) else $error("tx during fault");
  AST_WAKE_EDGE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wake_o |-> $past(state_q) == LINTP_WAKE_ARMED && $past(bus_s_q[1]))
    else $error("wake without armed edge");

  COV_TX: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) bus_oe_o);
  COV_FAULT: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    enable_q ##1 flt_s_q[1]);
  COV_WAKE: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) wake_o);
endmodule
